// ==== servo_off_pkg.sv ====
package servo_off_pkg;
   // ------------------------------------------------------------
   // Register map (word index, byte address is four times it)
   // ------------------------------------------------------------
   localparam logic [7:0] IDX_STOP_SELECT = 8'h69;
   localparam logic [7:0] IDX_STOPPED_DELAY = 8'h6A;
   localparam logic [7:0] IDX_RUNNING_DELAY = 8'h6B;
   localparam logic [7:0] IDX_STATUS = 8'h6F;
   localparam logic [7:0] IDX_SPEED_THRESH = 8'h6E;
   // ------------------------------------------------------------
   // Reset values and limits
   // ------------------------------------------------------------
   localparam logic [2:0] RST_STOP_SELECT = 3'h0;
   localparam logic [7:0] RST_STOPPED_DELAY = 8'h0A;
   localparam logic [7:0] RST_RUNNING_DELAY = 8'h32;
   localparam logic [15:0] RST_SPEED_THRESH = 16'h0032;
   localparam logic [7:0] MAX_DELAY = 8'h64;
   // ------------------------------------------------------------
   // Stop select field positions
   // ------------------------------------------------------------
   localparam int SEL_FREE_RUN_BIT = 0;
   localparam int SEL_SERVO_FREE_BIT = 1;
   localparam int SEL_HOLD_BIT = 2;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int TICK_MS = 2;
   localparam int TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   typedef enum logic [3:0] {
      ST_RUN = 4'h1,
      ST_STOP_WAIT = 4'h2,
      ST_DECEL = 4'h4,
      ST_OFF = 4'h8
   } seq_state_t;
endpackage : servo_off_pkg

// ==== tick_if.sv ====
`timescale 1ns/1ps
interface tick_if;
   logic clear;
   logic tick;
   modport source (input clear, output tick);
   modport sink (output clear, input tick);
endinterface : tick_if

// ==== tick_divider.sv ====
`timescale 1ns/1ps
module tick_divider
   import servo_off_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
)(
   input wire logic clk,
   input wire logic rst_n,
   tick_if.source tk
);
   logic [31:0] cnt_reg;

   // Restart on clear so the first tick is a full period after run falls
   always_ff @(posedge clk)
   begin
      if (!rst_n || tk.clear)
      begin
         cnt_reg <= 32'h0;
      end
      else if (cnt_reg == 32'(TICK_LEN - 1))
      begin
         cnt_reg <= 32'h0;
      end
      else
      begin
         cnt_reg <= cnt_reg + 32'h1;
      end
   end

   assign tk.tick = rst_n && !tk.clear && (cnt_reg == 32'(TICK_LEN - 1));
endmodule : tick_divider

// ==== servo_off_stop_brake_seq.sv ====
// Added by the designer: register access over Wishbone.
`timescale 1ns/1ps
module servo_off_stop_brake_seq
   import servo_off_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic run_cmd,
   input wire logic motor_stopped,
   input wire logic [15:0] motor_speed,
   output logic brake_interlock_output,
   output logic servo_on,
   output logic dyn_brake_on,
   output logic deviation_clear
);
   logic [2:0] stop_select_reg;
   logic [7:0] stopped_delay_reg;
   logic [7:0] running_delay_reg;
   logic [15:0] speed_thresh_reg;
   logic [2:0] latched_sel_reg;
   logic [7:0] tick_cnt_reg;
   logic run_d_reg;
   logic run_fall;
   logic dec;
   logic [7:0] idx;
   logic [31:0] rd_next;
   seq_state_t state_reg;
   tick_if tk ();

   tick_divider #(.TICK_LEN(TICK_LEN)) u_div (
      .clk(clk),
      .rst_n(rst_n),
      .tk(tk)
   );

   // ------------------------------------------------------------
   // Wishbone slave, one wait state, ack dropped after each access
   // ------------------------------------------------------------
   assign idx = wb_adr_i[9:2];
   assign dec = wb_cyc_i && wb_stb_i && !wb_ack_o;

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wb_ack_o <= 1'b0;
      end
      else
      begin
         wb_ack_o <= dec;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         stop_select_reg <= RST_STOP_SELECT;
         stopped_delay_reg <= RST_STOPPED_DELAY;
         running_delay_reg <= RST_RUNNING_DELAY;
         speed_thresh_reg <= RST_SPEED_THRESH;
      end
      else if (dec && wb_we_i)
      begin
         if (idx == IDX_STOP_SELECT && wb_sel_i[0])
         begin
            stop_select_reg <= wb_dat_i[2:0];
         end
         // Delays above the top of range are clamped
         if (idx == IDX_STOPPED_DELAY && wb_sel_i[0])
         begin
            stopped_delay_reg <= (wb_dat_i[7:0] > MAX_DELAY) ? MAX_DELAY : wb_dat_i[7:0];
         end
         if (idx == IDX_RUNNING_DELAY && wb_sel_i[0])
         begin
            running_delay_reg <= (wb_dat_i[7:0] > MAX_DELAY) ? MAX_DELAY : wb_dat_i[7:0];
         end
         if (idx == IDX_SPEED_THRESH)
         begin
            if (wb_sel_i[0])
            begin
               speed_thresh_reg[7:0] <= wb_dat_i[7:0];
            end
            if (wb_sel_i[1])
            begin
               speed_thresh_reg[15:8] <= wb_dat_i[15:8];
            end
         end
      end
   end

   always_comb
   begin
      rd_next = 32'h0;
      case (idx)
         IDX_STOP_SELECT: rd_next = {29'h0, stop_select_reg};
         IDX_STOPPED_DELAY: rd_next = {24'h0, stopped_delay_reg};
         IDX_RUNNING_DELAY: rd_next = {24'h0, running_delay_reg};
         IDX_SPEED_THRESH: rd_next = {16'h0, speed_thresh_reg};
         IDX_STATUS: rd_next = {24'h0, tick_cnt_reg[3:0], state_reg};
         default: rd_next = 32'h0;
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         wb_dat_o <= 32'h0;
      end
      else if (dec && !wb_we_i)
      begin
         wb_dat_o <= rd_next;
      end
   end

   // ------------------------------------------------------------
   // Run command edge and delay tick count
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         run_d_reg <= 1'b0;
      end
      else
      begin
         run_d_reg <= run_cmd;
      end
   end

   assign run_fall = run_d_reg && !run_cmd;
   assign tk.clear = run_fall || state_reg == ST_RUN;

   always_ff @(posedge clk)
   begin
      if (!rst_n || tk.clear)
      begin
         tick_cnt_reg <= 8'h0;
      end
      else if (tk.tick && tick_cnt_reg != 8'hFF)
      begin
         tick_cnt_reg <= tick_cnt_reg + 8'h1;
      end
   end

   // ------------------------------------------------------------
   // Sequence
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state_reg <= ST_OFF;
         latched_sel_reg <= RST_STOP_SELECT;
      end
      else
      begin
         case (state_reg)
            ST_RUN:
            begin
               if (!run_cmd)
               begin
                  latched_sel_reg <= stop_select_reg;
                  state_reg <= motor_stopped ? ST_STOP_WAIT : ST_DECEL;
               end
            end
            ST_STOP_WAIT:
            begin
               if (run_cmd)
               begin
                  state_reg <= ST_RUN;
               end
               else if (tick_cnt_reg >= stopped_delay_reg)
               begin
                  state_reg <= ST_OFF;
               end
            end
            ST_DECEL:
            begin
               if (run_cmd)
               begin
                  state_reg <= ST_RUN;
               end
               else if (tick_cnt_reg >= running_delay_reg || motor_speed <= speed_thresh_reg)
               begin
                  state_reg <= ST_OFF;
               end
            end
            ST_OFF:
            begin
               if (run_cmd)
               begin
                  state_reg <= ST_RUN;
               end
            end
            default: state_reg <= ST_OFF;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         brake_interlock_output <= 1'b0;
         servo_on <= 1'b0;
         dyn_brake_on <= 1'b0;
         deviation_clear <= 1'b0;
      end
      else
      begin
         // Interlock released only while running or decelerating
         // The leaving edge of RUN already follows the path taken, so no one-cycle dip
         brake_interlock_output <= (state_reg == ST_RUN && (run_cmd || !motor_stopped)) ||
                                   (state_reg == ST_DECEL);
         servo_on <= (state_reg == ST_RUN && (run_cmd || motor_stopped)) ||
                     (state_reg == ST_STOP_WAIT);
         case (state_reg)
            ST_DECEL: dyn_brake_on <= !latched_sel_reg[SEL_FREE_RUN_BIT];
            ST_OFF: dyn_brake_on <= !latched_sel_reg[SEL_SERVO_FREE_BIT];
            default: dyn_brake_on <= 1'b0;
         endcase
         deviation_clear <= state_reg != ST_RUN &&
                            !latched_sel_reg[SEL_HOLD_BIT];
      end
   end
endmodule : servo_off_stop_brake_seq

// ==== servo_off_chk.sv ====
`timescale 1ns/1ps
module servo_off_chk
   import servo_off_pkg::*;
#(
   parameter int TICK_LEN = TICK_CYCLES
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [31:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack_o,
   input wire logic run_cmd,
   input wire logic motor_stopped,
   input wire logic [15:0] motor_speed,
   input wire logic brake_interlock_output,
   input wire logic servo_on,
   input wire logic dyn_brake_on,
   input wire logic deviation_clear
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack missing");
   property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
   a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
   property p_ack_src; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_ack_src: assert property (p_ack_src) else $error("ack without request");
   property p_reset;
      disable iff (1'b0) !rst_n |=> !servo_on && !brake_interlock_output && !wb_ack_o;
   endproperty
   a_reset: assert property (p_reset) else $error("outputs active in reset");
   property p_run_on;
      run_cmd [*3] |-> servo_on && brake_interlock_output && !deviation_clear;
   endproperty
   a_run_on: assert property (p_run_on) else $error("run state outputs wrong");
   property p_stop_il;
      $fell(run_cmd) && motor_stopped |-> ##[2:3] !brake_interlock_output;
   endproperty
   a_stop_il: assert property (p_stop_il) else $error("interlock not dropped");
   property p_servo_stays; $fell(run_cmd) && motor_stopped && servo_on |=> servo_on; endproperty
   a_servo_stays: assert property (p_servo_stays) else $error("servo off early");
   property p_run_il;
      $fell(run_cmd) && !motor_stopped && brake_interlock_output |=> brake_interlock_output;
   endproperty
   a_run_il: assert property (p_run_il) else $error("interlock dropped early");
   property p_run_servo_off; $fell(run_cmd) && !motor_stopped |-> ##2 !servo_on; endproperty
   a_run_servo_off: assert property (p_run_servo_off) else $error("servo kept on");
   property p_low_speed;
      (!run_cmd && motor_speed <= RST_SPEED_THRESH) [*4] |-> !brake_interlock_output;
   endproperty
   a_low_speed: assert property (p_low_speed) else $error("interlock held slow");
endmodule : servo_off_chk

bind servo_off_stop_brake_seq servo_off_chk #(.TICK_LEN(TICK_LEN)) u_chk (
   .clk(clk),
   .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i),
   .wb_we_i(wb_we_i),
   .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i),
   .wb_dat_i(wb_dat_i),
   .wb_dat_o(wb_dat_o),
   .wb_ack_o(wb_ack_o),
   .run_cmd(run_cmd),
   .motor_stopped(motor_stopped),
   .motor_speed(motor_speed),
   .brake_interlock_output(brake_interlock_output),
   .servo_on(servo_on),
   .dyn_brake_on(dyn_brake_on),
   .deviation_clear(deviation_clear)
);

// ==== host_ctl.sv ====
`timescale 1ns/1ps
module host_ctl (
   input wire logic clk,
   output logic run_cmd = 1'b0,
   output logic motor_stopped = 1'b1,
   output logic [15:0] motor_speed = 16'h0
);
   task automatic go(input logic [15:0] spd);
      @(posedge clk);
      run_cmd <= 1'b1;
      motor_stopped <= (spd == 16'h0);
      motor_speed <= spd;
   endtask : go
   task automatic halt();
      @(posedge clk);
      run_cmd <= 1'b0;
   endtask : halt
   task automatic set_speed(input logic [15:0] spd);
      @(posedge clk);
      motor_speed <= spd;
   endtask : set_speed
endmodule : host_ctl

// ==== servo_off_stop_brake_seq_bench.sv ====
`timescale 1ns/1ps
module servo_off_stop_brake_seq_bench
   import servo_off_pkg::*;
;
   logic clk = 0, rst_n = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
   logic [31:0] wb_adr_i = 0, wb_dat_i = 0, wb_dat_o;
   logic [3:0] wb_sel_i = 0;
   logic run_cmd, motor_stopped, brake_interlock_output, servo_on;
   logic dyn_brake_on, deviation_clear;
   logic [15:0] motor_speed;
   logic [31:0] exp_q[$];
   int mismatches = 0, num_checks = 0;
   always #5 clk = ~clk;
   servo_off_stop_brake_seq #(.TICK_LEN(10)) DUT (.*);
   host_ctl HOST (.*);
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp)
      begin
         mismatches++;
         $display("ERROR %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk_reg
   task automatic chk_out(input logic got, input logic exp);
      chk_reg({31'h0, got}, {31'h0, exp});
   endtask : chk_out
   task automatic wb(input logic we, input logic [7:0] idx, input logic [31:0] d);
      @(posedge clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_sel_i <= 4'hF;
      wb_adr_i <= {22'h0, idx, 2'h0};
      wb_dat_i <= d;
      do @(posedge clk); while (wb_ack_o !== 1'b1);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask : wb
   task automatic rd(input logic [7:0] idx, input logic [31:0] e);
      exp_q.push_back(e);
      wb(1'b0, idx, 32'h0);
   endtask : rd
   always @(posedge clk)
      if (wb_ack_o === 1'b1 && !wb_we_i) chk_reg(wb_dat_o, exp_q.pop_front());
   task automatic finish_test();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : finish_test
   initial
   begin
      repeat (6000) @(posedge clk);
      mismatches++;
      finish_test();
   end
   initial
   begin
      void'($urandom(32'h09B4A211));
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      rd(IDX_STOP_SELECT, {29'h0, RST_STOP_SELECT});
      rd(IDX_STOPPED_DELAY, {24'h0, RST_STOPPED_DELAY});
      rd(IDX_RUNNING_DELAY, {24'h0, RST_RUNNING_DELAY});
      rd(IDX_SPEED_THRESH, {16'h0, RST_SPEED_THRESH});
      wb(1'b1, 8'h10, 32'h5A);
      rd(8'h10, 32'h0);
      wb(1'b1, IDX_STOPPED_DELAY, 32'hFF);
      rd(IDX_STOPPED_DELAY, {24'h0, MAX_DELAY});
      wb(1'b1, IDX_STOPPED_DELAY, 32'h4);
      wb(1'b1, IDX_RUNNING_DELAY, 32'h3);
      for (int i = 0; i < 16; i++)
      begin
         wb(1'b1, IDX_STOP_SELECT, 32'(i % 8));
         HOST.go(i < 8 ? 16'h0 : 16'(16'h0100 + $urandom % 1000));
         repeat (5) @(posedge clk);
         HOST.halt();
         repeat (4) @(posedge clk);
         chk_out(brake_interlock_output, i >= 8);
         if (i >= 8) chk_out(dyn_brake_on, !i[0]);
         repeat (20) @(posedge clk);
         if (i < 8) chk_out(servo_on, 1'b1);
         chk_out(brake_interlock_output, i >= 8);
         repeat (30) @(posedge clk);
         chk_out(servo_on, 1'b0);
         chk_out(brake_interlock_output, 1'b0);
         chk_out(dyn_brake_on, !i[1]);
         chk_out(deviation_clear, !i[2]);
      end
      wb(1'b1, IDX_RUNNING_DELAY, 32'h64);
      HOST.go(16'h0200);
      repeat (5) @(posedge clk);
      HOST.halt();
      repeat (10) @(posedge clk);
      chk_out(brake_interlock_output, 1'b1);
      HOST.set_speed(RST_SPEED_THRESH);
      repeat (5) @(posedge clk);
      chk_out(brake_interlock_output, 1'b0);
      finish_test();
   end
endmodule : servo_off_stop_brake_seq_bench
